// >>> eud_decoder.sv
// branch, loop, trap and processor-control opcode decoder fed from the prefetch path
// Summary of operation
// - 0x70 branches on overflow set, 0x71 on overflow clear, with displacement byte
// - 0x78 branches on sign set, 0x79 on sign clear
// - 0x74 branches on zero set, 0x75 on zero clear
// - 0x72 branches on unsigned below, 0x73 on unsigned above-or-equal
// - 0x76 branches on unsigned below-or-equal, 0x77 on unsigned above
// - 0x7A branches on parity even, 0x7B on parity odd
// - 0x7C branches on signed less, 0x7D on signed greater-or-equal
// - 0x7E branches on signed less-or-equal, 0x7F on signed greater
// - greater/less compare signed; above/below compare unsigned
// - 0xE2 loops on count, 0xE1 also needs zero set, 0xE0 zero clear
// - 0xE3 branches only when the count register is zero
// - 0xCD typed trap, 0xCC type 3, 0xCE trap on overflow, 0xCF return
// - 0xF8, 0xF5, 0xF9 clear, invert and set carry
// - 0xFC clears direction, 0xFD sets it
// - 0xFA clears interrupt enable, 0xFB sets it
// - 0xF4 halt, 0x9B wait, 0xF0 locks the bus for the next instruction
// - width bit one means word operation, zero means byte
// - direction bit one makes the register field the destination
// - count-select bit zero shifts by one, else by count low byte
// - sign and width both set sign-extend one immediate byte
// - register code 000 is accumulator, 001 count; segment 00 extra, 01 code
// - mode picks no (two if r/m is 110), one sign-extended, or two displacement bytes; 11 register
// - flags word bit positions carry 0 through overflow 11
`timescale 1ns/1ns
module eud_decoder
	import eud_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	input wire logic [15:0] nextIp,
	input wire logic [15:0] flagsIn,
	input wire logic [15:0] countIn,
	input wire logic operandValid,
	input wire logic [7:0] operandByte,
	output logic instrDone,
	output eud_class_t instrClass,
	output logic branchTaken,
	output logic [15:0] branchTarget,
	output logic countDecrement,
	output logic intRequest,
	output logic [7:0] intType,
	output logic intReturn,
	output logic haltRequest,
	output logic waitRequest,
	output logic busLock,
	output logic flagsWrite,
	output logic [15:0] flagsOut,
	output eud_fields_t opFields,
	output logic unknownOp,
	output logic awaitingByte
);
	eud_state_t q;
	eud_state_t d;
	logic condTaken;
	logic acceptOpc;
	logic acceptDisp;
	logic [7:0] opSel;
	logic [7:0] modrmSel;
	logic [15:0] dispSext;
	logic [15:0] takenTgt;
	logic countLast;
	logic countZero;
	eud_fields_t fieldsNext;

	// byte hand-off is qualified by the clock enable so a frozen cycle takes nothing
	assign acceptOpc = ce && byteValid && (q.state == ST_OPC);
	assign acceptDisp = ce && byteValid && (q.state == ST_DISP);

	// the displacement byte is sign-extended before the add
	assign dispSext = {{8{byteData[7]}}, byteData};
	assign takenTgt = nextIp + dispSext;

	// loop decrements first, so the last pass is when the count is one now
	assign countLast = (countIn == COUNT_ONE);
	assign countZero = (countIn == COUNT_ZERO);

	// field decode looks at the byte being taken, else the one already held
	assign opSel = acceptOpc ? byteData : q.opcode;
	assign modrmSel = (ce && operandValid) ? operandByte : q.modrm;

	eud_cond_eval u_cond (
		.cond(q.opcode[3:0]),
		.flags(flagsIn),
		.taken(condTaken)
	);

	eud_field_dec u_fields (
		.opByte(opSel),
		.modrmByte(modrmSel),
		.fields(fieldsNext)
	);

	// next-state logic: pulses drop back each cycle, levels are held
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.taken = 1'b0;
		d.countDec = 1'b0;
		d.intReq = 1'b0;
		d.intRet = 1'b0;
		d.halt = 1'b0;
		d.waitReq = 1'b0;
		d.flagsWr = 1'b0;
		d.unknownOp = 1'b0;
		d.opcode = opSel;
		d.modrm = modrmSel;
		d.fields = fieldsNext;
		case (q.state)
			ST_OPC: begin
				if (byteValid) begin
					// lock covers exactly the instruction after the prefix
					d.busLock = q.lockPend;
					d.lockPend = 1'b0;
					if (byteData[7:4] == OP_BR_HI) begin
						d.state = ST_DISP;
						d.cls = CL_BRANCH;
					end else if (byteData[7:2] == OP_LOOP_HI) begin
						d.state = ST_DISP;
						d.cls = CL_LOOP;
					end else begin
						d.done = 1'b1;
						case (byteData)
							OP_INT_TYPED: begin
								d.done = 1'b0;
								d.state = ST_TYPE;
								d.cls = CL_SWINT;
							end
							OP_INT3: begin
								d.intReq = 1'b1;
								d.intType = INT3_TYPE;
								d.cls = CL_SWINT;
							end
							OP_INT_OVF: begin
								// trap fires only with overflow set, else a no-op
								d.intReq = flagsIn[FB_OVF];
								d.intType = INT_OVF_TYPE;
								d.cls = CL_SWINT;
							end
							OP_TRAP_RETURN: begin
								d.intRet = 1'b1;
								d.cls = CL_TRAP_RETURN;
							end
							OP_CLC: begin
								d.flagsWr = 1'b1;
								d.flagsOut = flagsIn;
								d.flagsOut[FB_CARRY] = 1'b0;
								d.cls = CL_FLAG;
							end
							OP_CMC: begin
								d.flagsWr = 1'b1;
								d.flagsOut = flagsIn;
								d.flagsOut[FB_CARRY] = ~flagsIn[FB_CARRY];
								d.cls = CL_FLAG;
							end
							OP_STC: begin
								d.flagsWr = 1'b1;
								d.flagsOut = flagsIn;
								d.flagsOut[FB_CARRY] = 1'b1;
								d.cls = CL_FLAG;
							end
							OP_CLD: begin
								d.flagsWr = 1'b1;
								d.flagsOut = flagsIn;
								d.flagsOut[FB_DIR] = 1'b0;
								d.cls = CL_FLAG;
							end
							OP_STD: begin
								d.flagsWr = 1'b1;
								d.flagsOut = flagsIn;
								d.flagsOut[FB_DIR] = 1'b1;
								d.cls = CL_FLAG;
							end
							OP_CLI: begin
								d.flagsWr = 1'b1;
								d.flagsOut = flagsIn;
								d.flagsOut[FB_IRQ] = 1'b0;
								d.cls = CL_FLAG;
							end
							OP_STI: begin
								d.flagsWr = 1'b1;
								d.flagsOut = flagsIn;
								d.flagsOut[FB_IRQ] = 1'b1;
								d.cls = CL_FLAG;
							end
							OP_HLT: begin
								d.halt = 1'b1;
								d.cls = CL_HALT;
							end
							OP_WAIT: begin
								d.waitReq = 1'b1;
								d.cls = CL_WAIT;
							end
							OP_LOCK: begin
								d.lockPend = 1'b1;
								d.cls = CL_LOCK;
							end
							default: begin
								// anything else belongs to another decoder
								d.unknownOp = 1'b1;
								d.cls = CL_OTHER;
							end
						endcase
					end
				end
			end
			ST_DISP: begin
				if (byteValid) begin
					d.done = 1'b1;
					d.state = ST_OPC;
					if (q.cls == CL_BRANCH) begin
						d.taken = condTaken;
					end else begin
						case (q.opcode)
							OP_LOOP: begin
								d.countDec = 1'b1;
								d.taken = ~countLast;
							end
							OP_LOOP_EQ: begin
								d.countDec = 1'b1;
								d.taken = ~countLast & flagsIn[FB_ZERO];
							end
							OP_LOOP_NE: begin
								d.countDec = 1'b1;
								d.taken = ~countLast & ~flagsIn[FB_ZERO];
							end
							default: d.taken = countZero;
						endcase
					end
					// not taken falls through to the next sequential address
					d.target = d.taken ? takenTgt : nextIp;
				end
			end
			ST_TYPE: begin
				if (byteValid) begin
					d.done = 1'b1;
					d.state = ST_OPC;
					d.intReq = 1'b1;
					d.intType = byteData;
				end
			end
			default: d.state = ST_OPC;
		endcase
		// kept as its own flop so the wait indication leaves the block unglitched
		d.awaiting = (d.state != ST_OPC);
	end

	// single register stage; clock enable freezes every bit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= STATE_RESET;
		end else if (ce) begin
			q <= d;
		end
	end

	// all outputs are taken straight from the state register
	assign instrDone = q.done;
	assign instrClass = q.cls;
	assign branchTaken = q.taken;
	assign branchTarget = q.target;
	assign countDecrement = q.countDec;
	assign intRequest = q.intReq;
	assign intType = q.intType;
	assign intReturn = q.intRet;
	assign haltRequest = q.halt;
	assign waitRequest = q.waitReq;
	assign busLock = q.busLock;
	assign flagsWrite = q.flagsWr;
	assign flagsOut = q.flagsOut;
	assign opFields = q.fields;
	assign unknownOp = q.unknownOp;
	assign awaitingByte = q.awaiting;

	// helper terms sampled by the checks below
	logic sltNow;
	logic beNow;
	logic opcIsInt3;
	logic opcIsClc;
	assign sltNow = flagsIn[FB_SIGN] ^ flagsIn[FB_OVF];
	assign beNow = flagsIn[FB_CARRY] | flagsIn[FB_ZERO];
	assign opcIsInt3 = acceptOpc && (byteData == OP_INT3);
	assign opcIsClc = acceptOpc && (byteData == OP_CLC);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_br_ovf;
		acceptDisp && (q.opcode == OP_BR_OVF) |=> instrDone && (branchTaken == $past(flagsIn[FB_OVF]));
	endproperty
	a_br_ovf: assert property (p_br_ovf) else $error("overflow branch decision wrong");

	property p_br_eq;
		acceptDisp && (q.opcode == OP_BR_EQ) |=> branchTaken == $past(flagsIn[FB_ZERO]);
	endproperty
	a_br_eq: assert property (p_br_eq) else $error("equal branch decision wrong");

	property p_br_be;
		acceptDisp && (q.opcode == OP_BR_BE) |=> branchTaken == $past(beNow);
	endproperty
	a_br_be: assert property (p_br_be) else $error("below-or-equal decision wrong");

	property p_br_slt;
		acceptDisp && (q.opcode == OP_BR_SLT) |=> branchTaken == $past(sltNow);
	endproperty
	a_br_slt: assert property (p_br_slt) else $error("signed less decision wrong");

	property p_loop;
		acceptDisp && (q.opcode == OP_LOOP) |=> countDecrement && (branchTaken == !$past(countLast));
	endproperty
	a_loop: assert property (p_loop) else $error("loop decision wrong");

	property p_cntz;
		acceptDisp && (q.opcode == OP_BR_CNTZ) |=> !countDecrement && (branchTaken == $past(countZero));
	endproperty
	a_cntz: assert property (p_cntz) else $error("count-zero branch wrong");

	property p_int3;
		opcIsInt3 |=> intRequest && instrDone && (intType == INT3_TYPE)
			##1 (!intRequest || !$past(ce) || $past(acceptOpc));
	endproperty
	a_int3: assert property (p_int3) else $error("type 3 trap not raised");

	property p_clc;
		opcIsClc |=> flagsWrite && !flagsOut[FB_CARRY] && (flagsOut[FB_DIR] == $past(flagsIn[FB_DIR]));
	endproperty
	a_clc: assert property (p_clc) else $error("carry clear wrong");

	property p_lock;
		acceptOpc && q.lockPend |=> busLock;
	endproperty
	a_lock: assert property (p_lock) else $error("lock not applied to next instruction");

	property p_target;
		acceptDisp |=> branchTarget == (branchTaken ? $past(takenTgt) : $past(nextIp));
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong");

	property p_cov_taken;
		acceptDisp && (q.cls == CL_BRANCH) ##1 branchTaken;
	endproperty
	c_cov_taken: cover property (p_cov_taken);

	property p_cov_loop;
		acceptDisp && (q.cls == CL_LOOP) ##1 countDecrement;
	endproperty
	c_cov_loop: cover property (p_cov_loop);

	property p_cov_typed;
		acceptOpc && (byteData == OP_INT_TYPED) ##1 (acceptDisp || (ce && byteValid)) ##1 intRequest;
	endproperty
	c_cov_typed: cover property (p_cov_typed);
endmodule : eud_decoder

// >>> eud_pkg.sv
// shared constants, types and state layout for the branch/control opcode decoder
package eud_pkg;
	// conditional branch family shares the upper nibble, loop family the upper six bits
	localparam logic [3:0] OP_BR_HI = 4'h7;
	localparam logic [5:0] OP_LOOP_HI = 6'h38;
	localparam logic [7:0] OP_BR_OVF = 8'h70;
	localparam logic [7:0] OP_BR_NOVF = 8'h71;
	localparam logic [7:0] OP_BR_BELOW = 8'h72;
	localparam logic [7:0] OP_BR_EQ = 8'h74;
	localparam logic [7:0] OP_BR_BE = 8'h76;
	localparam logic [7:0] OP_BR_SLT = 8'h7C;
	localparam logic [7:0] OP_BR_SLE = 8'h7E;
	localparam logic [7:0] OP_LOOP_NE = 8'hE0;
	localparam logic [7:0] OP_LOOP_EQ = 8'hE1;
	localparam logic [7:0] OP_LOOP = 8'hE2;
	localparam logic [7:0] OP_BR_CNTZ = 8'hE3;
	localparam logic [7:0] OP_INT3 = 8'hCC;
	localparam logic [7:0] OP_INT_TYPED = 8'hCD;
	localparam logic [7:0] OP_INT_OVF = 8'hCE;
	localparam logic [7:0] OP_TRAP_RETURN = 8'hCF;
	localparam logic [7:0] OP_CLC = 8'hF8;
	localparam logic [7:0] OP_CMC = 8'hF5;
	localparam logic [7:0] OP_STC = 8'hF9;
	localparam logic [7:0] OP_CLD = 8'hFC;
	localparam logic [7:0] OP_STD = 8'hFD;
	localparam logic [7:0] OP_CLI = 8'hFA;
	localparam logic [7:0] OP_STI = 8'hFB;
	localparam logic [7:0] OP_HLT = 8'hF4;
	localparam logic [7:0] OP_WAIT = 8'h9B;
	localparam logic [7:0] OP_LOCK = 8'hF0;
	// interrupt type numbers carried by the one-byte trap opcodes
	localparam logic [7:0] INT3_TYPE = 8'h03;
	localparam logic [7:0] INT_OVF_TYPE = 8'h04;
	// flags word bit positions
	localparam int FB_CARRY = 0;
	localparam int FB_PARITY = 2;
	localparam int FB_AUX = 4;
	localparam int FB_ZERO = 6;
	localparam int FB_SIGN = 7;
	localparam int FB_TRAP = 8;
	localparam int FB_IRQ = 9;
	localparam int FB_DIR = 10;
	localparam int FB_OVF = 11;
	// operand field codes
	localparam logic [2:0] REG_ACC = 3'h0;
	localparam logic [2:0] REG_CNT = 3'h1;
	localparam logic [1:0] SEG_EXTRA = 2'h0;
	localparam logic [1:0] SEG_CODE = 2'h1;
	localparam logic [1:0] MOD_NODISP = 2'h0;
	localparam logic [1:0] MOD_DISP8 = 2'h1;
	localparam logic [1:0] MOD_DISP16 = 2'h2;
	localparam logic [2:0] RM_DIRECT = 3'h6;
	localparam logic [1:0] SW_SEXT = 2'h3;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		ST_OPC = 3'b001,
		ST_DISP = 3'b010,
		ST_TYPE = 3'b100
	} eud_fsm_t;

	typedef enum logic [3:0] {
		CL_NONE, CL_BRANCH, CL_LOOP, CL_SWINT, CL_TRAP_RETURN,
		CL_FLAG, CL_HALT, CL_WAIT, CL_LOCK, CL_OTHER
	} eud_class_t;

	typedef struct packed {
		logic wide;
		logic regIsDest;
		logic shiftByOne;
		logic immSignExt;
		logic regIsAccum;
		logic regIsCount;
		logic segIsExtra;
		logic segIsCode;
		logic [1:0] dispBytes;
		logic dispSext;
		logic rmIsReg;
	} eud_fields_t;

	typedef struct packed {
		eud_fsm_t state;
		logic [7:0] opcode;
		logic [7:0] modrm;
		logic lockPend;
		logic done;
		eud_class_t cls;
		logic taken;
		logic [15:0] target;
		logic countDec;
		logic intReq;
		logic [7:0] intType;
		logic intRet;
		logic halt;
		logic waitReq;
		logic busLock;
		logic flagsWr;
		logic [15:0] flagsOut;
		eud_fields_t fields;
		logic unknownOp;
		logic awaiting;
	} eud_state_t;

	localparam eud_state_t STATE_RESET = '{state: ST_OPC, cls: CL_NONE, default: '0};
endpackage : eud_pkg

// >>> eud_cond_eval.sv
// branch condition evaluation from the low opcode nibble and the flags word
`timescale 1ns/1ns
module eud_cond_eval
	import eud_pkg::*;
(
	input wire logic [3:0] cond,
	input wire logic [15:0] flags,
	output logic taken
);
	logic base;
	logic lessSigned;

	// signed less is sign differing from overflow, unsigned below is carry
	assign lessSigned = flags[FB_SIGN] ^ flags[FB_OVF];

	// odd codes test the opposite sense of the even code below them
	always_comb begin
		case (cond[3:1])
			3'h0: base = flags[FB_OVF];
			3'h1: base = flags[FB_CARRY];
			3'h2: base = flags[FB_ZERO];
			3'h3: base = flags[FB_CARRY] | flags[FB_ZERO];
			3'h4: base = flags[FB_SIGN];
			3'h5: base = flags[FB_PARITY];
			3'h6: base = lessSigned;
			3'h7: base = lessSigned | flags[FB_ZERO];
			default: base = 1'b0;
		endcase
		taken = base ^ cond[0];
	end
endmodule : eud_cond_eval

// >>> eud_field_dec.sv
// operand field decode of an opcode byte and its mode/register byte
`timescale 1ns/1ns
module eud_field_dec
	import eud_pkg::*;
(
	input wire logic [7:0] opByte,
	input wire logic [7:0] modrmByte,
	output eud_fields_t fields
);
	logic [1:0] modField;

	assign modField = modrmByte[7:6];

	// bit meanings are only valid for opcodes that carry the field
	always_comb begin
		fields = '0;
		fields.wide = opByte[0];
		fields.regIsDest = opByte[1];
		fields.shiftByOne = ~opByte[1];
		fields.immSignExt = (opByte[1:0] == SW_SEXT);
		fields.regIsAccum = (modrmByte[5:3] == REG_ACC);
		fields.regIsCount = (modrmByte[5:3] == REG_CNT);
		fields.segIsExtra = (modrmByte[4:3] == SEG_EXTRA);
		fields.segIsCode = (modrmByte[4:3] == SEG_CODE);
		case (modField)
			MOD_NODISP: fields.dispBytes = (modrmByte[2:0] == RM_DIRECT) ? 2'h2 : 2'h0;
			MOD_DISP8: begin
				fields.dispBytes = 2'h1;
				fields.dispSext = 1'b1;
			end
			MOD_DISP16: fields.dispBytes = 2'h2;
			default: fields.rmIsReg = 1'b1;
		endcase
	end
endmodule : eud_field_dec

// >>> eud_prog_mem.sv
// program memory model feeding instruction bytes through the prefetch path
`timescale 1ns/1ns
module eud_prog_mem
	import eud_pkg::*;
#(
	parameter logic [15:0] START_IP = 16'h0100
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic feedValid,
	input wire logic [7:0] feedByte,
	output logic byteValid,
	output logic [7:0] byteData,
	output logic [15:0] nextIp
);
	logic [15:0] ipQ;
	logic [7:0] lastQ;

	// address advances only on bytes the decoder really takes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ipQ <= START_IP;
			lastQ <= 8'h00;
		end else if (ce && feedValid) begin
			ipQ <= ipQ + 16'h0001;
			lastQ <= feedByte;
		end
	end

	// an idle bus shows the inverse of the last byte so stale data never looks valid
	assign byteValid = feedValid;
	assign byteData = feedValid ? feedByte : ~lastQ;
	assign nextIp = ipQ + 16'h0001;
endmodule : eud_prog_mem

// >>> eud_decoder_tb.sv
// self-checking bench for the branch and control opcode decoder
`timescale 1ns/1ns
module eud_decoder_tb;
	import eud_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b0;
	logic feedValid = 1'b0;
	logic [7:0] feedByte = 8'h00;
	logic [15:0] flagsIn = 16'h0000;
	logic [15:0] countIn = 16'h0000;
	logic operandValid = 1'b0;
	logic [7:0] operandByte = 8'h00;
	logic byteValid, instrDone, branchTaken, countDecrement, intRequest, intReturn;
	logic haltRequest, waitRequest, busLock, flagsWrite, unknownOp, awaitingByte;
	logic [7:0] byteData, intType, d;
	logic [15:0] nextIp, branchTarget, flagsOut, tgt, dispNext;
	logic [15:0] ipTb = 16'h0100;
	eud_class_t instrClass;
	eud_fields_t opFields;
	logic t;
	int errTotal = 0;
	int totalChecks = 0;
	logic [15:0] fpat [8] = '{16'h0000, 16'h0001, 16'h0040, 16'h0080, 16'h0800,
		16'h0880, 16'h0004, 16'h0041};
	logic [7:0] lpOp [9] = '{8'hE2, 8'hE2, 8'hE1, 8'hE1, 8'hE0, 8'hE0, 8'hE0, 8'hE3, 8'hE3};
	logic [15:0] lpCnt [9] = '{16'h0005, 16'h0001, 16'h0005, 16'h0005, 16'h0005, 16'h0005,
		16'h0001, 16'h0000, 16'h0001};
	logic [15:0] lpFlg [9] = '{16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0040,
		16'h0000, 16'h0000, 16'h0000};

	always #4 clk = ~clk;

	eud_prog_mem eud_prog_mem_inst (.clk(clk), .resetn(resetn), .ce(ce), .feedValid(feedValid),
		.feedByte(feedByte), .byteValid(byteValid), .byteData(byteData), .nextIp(nextIp));

	eud_decoder eud_decoder_inst (.clk(clk), .resetn(resetn), .ce(ce), .byteValid(byteValid),
		.byteData(byteData), .nextIp(nextIp), .flagsIn(flagsIn), .countIn(countIn),
		.operandValid(operandValid), .operandByte(operandByte), .instrDone(instrDone),
		.instrClass(instrClass), .branchTaken(branchTaken), .branchTarget(branchTarget),
		.countDecrement(countDecrement), .intRequest(intRequest), .intType(intType),
		.intReturn(intReturn), .haltRequest(haltRequest), .waitRequest(waitRequest),
		.busLock(busLock), .flagsWrite(flagsWrite), .flagsOut(flagsOut), .opFields(opFields),
		.unknownOp(unknownOp), .awaitingByte(awaitingByte));

	task automatic completeRun();
		$display("checks %0d mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : completeRun

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		totalChecks++;
		if (seen !== exp) begin
			errTotal++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// present one byte at this edge; it is taken at the next one
	task automatic put(input logic [7:0] b);
		feedValid <= 1'b1;
		feedByte <= b;
		dispNext = ipTb + 16'h0001;
		ipTb = ipTb + 16'h0001;
		@(posedge clk);
	endtask : put

	// whole instruction, then look in the cycle where its pulses stand
	task automatic run(input logic [7:0] op, input logic two, input logic [7:0] b2);
		put(op);
		if (two) begin
			put(b2);
		end
		feedValid <= 1'b0;
		#1;
		chk(instrDone, 1'b1, "done");
	endtask : run

	task automatic trap(input logic [7:0] op, input logic two, input logic [7:0] b2,
		input logic [15:0] f, input logic req, input logic [7:0] typ, input logic ret);
		flagsIn <= f;
		run(op, two, b2);
		chk(intRequest, req, "trap request");
		if (req) begin
			chk(intType, typ, "trap type");
		end
		chk(intReturn, ret, "trap return");
		@(posedge clk);
	endtask : trap

	task automatic flg(input logic [7:0] op, input logic [15:0] fin, input logic [15:0] fexp);
		flagsIn <= fin;
		run(op, 1'b0, 8'h00);
		chk(flagsWrite, 1'b1, "flag write");
		chk(flagsOut, fexp, "flag value");
		@(posedge clk);
	endtask : flg

	// operand fields come from the held opcode and the mode byte
	task automatic fld(input logic [7:0] op, input logic [7:0] mb, input eud_fields_t exp);
		run(op, 1'b0, 8'h00);
		@(posedge clk);
		operandValid <= 1'b1;
		operandByte <= mb;
		repeat (2) @(posedge clk);
		#1;
		chk(opFields, exp, "operand fields");
		@(posedge clk);
		operandValid <= 1'b0;
	endtask : fld

	// reference branch condition from the low opcode nibble
	function automatic logic condOk(input logic [3:0] c, input logic [15:0] f);
		logic r;
		case (c[3:1])
			3'h0: r = f[FB_OVF];
			3'h1: r = f[FB_CARRY];
			3'h2: r = f[FB_ZERO];
			3'h3: r = f[FB_CARRY] | f[FB_ZERO];
			3'h4: r = f[FB_SIGN];
			3'h5: r = f[FB_PARITY];
			3'h6: r = f[FB_SIGN] ^ f[FB_OVF];
			default: r = (f[FB_SIGN] ^ f[FB_OVF]) | f[FB_ZERO];
		endcase
		return r ^ c[0];
	endfunction : condOk

	// a hang must still end with a verdict
	initial begin
		#100000;
		errTotal++;
		completeRun();
	end

	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		ce <= 1'b1;
		@(posedge clk);
		#1;
		chk(instrDone, 1'b0, "reset done");
		chk(busLock, 1'b0, "reset lock");
		chk(flagsOut, 16'h0000, "reset flags");
		@(posedge clk);
		// every condition against a spread of flag words, both displacement signs
		for (int c = 0; c < 16; c++) begin
			for (int k = 0; k < 8; k++) begin
				flagsIn <= fpat[k];
				d = k[0] ? 8'h80 : 8'h7F;
				run({OP_BR_HI, 4'(c)}, 1'b1, d);
				t = condOk(4'(c), fpat[k]);
				tgt = t ? dispNext + {{8{d[7]}}, d} : dispNext;
				chk(instrClass, CL_BRANCH, "branch class");
				chk(branchTaken, t, "branch taken");
				chk(branchTarget, tgt, "branch target");
				@(posedge clk);
			end
		end
		// counted loops and count-zero branch
		for (int i = 0; i < 9; i++) begin
			flagsIn <= lpFlg[i];
			countIn <= lpCnt[i];
			run(lpOp[i], 1'b1, 8'hF0);
			if (lpOp[i] == 8'hE3) begin
				t = (lpCnt[i] == 16'h0000);
			end else begin
				t = (lpCnt[i] != 16'h0001) && (lpOp[i] == 8'hE2 ||
					(lpFlg[i][FB_ZERO] == (lpOp[i] == 8'hE1)));
			end
			chk(branchTaken, t, "loop taken");
			chk(countDecrement, lpOp[i] != 8'hE3, "loop decrement");
			chk(branchTarget, t ? dispNext - 16'h0010 : dispNext, "loop target");
			@(posedge clk);
		end
		trap(OP_INT_TYPED, 1'b1, 8'h21, 16'h0000, 1'b1, 8'h21, 1'b0);
		trap(OP_INT3, 1'b0, 8'h00, 16'h0000, 1'b1, 8'h03, 1'b0);
		trap(OP_INT_OVF, 1'b0, 8'h00, 16'h0800, 1'b1, INT_OVF_TYPE, 1'b0);
		trap(OP_INT_OVF, 1'b0, 8'h00, 16'h0000, 1'b0, 8'h00, 1'b0);
		trap(OP_TRAP_RETURN, 1'b0, 8'h00, 16'h0000, 1'b0, 8'h00, 1'b1);
		flg(8'hF8, 16'hFFFF, 16'hFFFE);
		flg(8'hF5, 16'h0001, 16'h0000);
		flg(8'hF9, 16'h0000, 16'h0001);
		flg(8'hFC, 16'h0400, 16'h0000);
		flg(8'hFD, 16'h0000, 16'h0400);
		flg(8'hFA, 16'h0200, 16'h0000);
		flg(8'hFB, 16'h0000, 16'h0200);
		// back to back flag ops, each uses the flags of its own opcode cycle
		flagsIn <= 16'h00F1;
		put(8'hF8);
		feedByte <= 8'hF9;
		flagsIn <= 16'h00F0;
		ipTb = ipTb + 16'h0001;
		#1;
		chk(flagsOut, 16'h00F0, "first of pair");
		@(posedge clk);
		feedValid <= 1'b0;
		#1;
		chk(flagsOut, 16'h00F1, "second of pair");
		@(posedge clk);
		run(OP_HLT, 1'b0, 8'h00);
		chk(haltRequest, 1'b1, "halt");
		@(posedge clk);
		run(OP_WAIT, 1'b0, 8'h00);
		chk(waitRequest, 1'b1, "wait");
		@(posedge clk);
		run(OP_LOCK, 1'b0, 8'h00);
		chk(instrClass, CL_LOCK, "lock class");
		@(posedge clk);
		run(OP_CLC, 1'b0, 8'h00);
		chk(busLock, 1'b1, "locked instruction");
		@(posedge clk);
		run(OP_STC, 1'b0, 8'h00);
		chk(busLock, 1'b0, "lock released");
		@(posedge clk);
		run(8'h90, 1'b0, 8'h00);
		chk(unknownOp, 1'b1, "unknown opcode");
		@(posedge clk);
		// a frozen clock enable must ignore the byte on offer
		flagsIn <= 16'h0040;
		put(OP_BR_EQ);
		ce <= 1'b0;
		feedByte <= OP_HLT;
		repeat (3) @(posedge clk);
		#1;
		chk(awaitingByte, 1'b1, "frozen waiting");
		chk(instrDone, 1'b0, "frozen done");
		@(posedge clk);
		ce <= 1'b1;
		run(8'h10, 1'b0, 8'h00);
		chk(branchTarget, dispNext + 16'h0010, "after freeze");
		@(posedge clk);
		fld(8'h83, 8'h4E, 12'hD56);
		fld(8'h00, 8'hC6, 12'h2A1);
		fld(8'h00, 8'h06, 12'h2A8);
		completeRun();
	end
endmodule : eud_decoder_tb
